// file: hw/cae_engine.v
// Core arithmetic engine: integer ALU, multiplier, iterative divider and
// DSP accumulator datapath. Operands come from the decoder which has read
// the working registers or data memory; results go back the same way.
`timescale 1ns/1ps
`default_nettype none
`include "cae_engine_regs.vh"

////////////////////////////////////////////////////////////////////////////////
// Function
// - ALU is 16 bits wide: add, subtract, shift and logic.
// - Arithmetic is two's complement unless stated otherwise.
// - ALU updates carry, zero, negative, overflow and half-carry flags.
// - On subtract carry and half-carry mean not-borrow.
// - Byte or word width per instruction; flags follow that width.
// - Operands from registers or memory; result back to either.
// - 17x17 multiplier: signed, unsigned and both mixed orders.
// - Word times an unsigned 5-bit literal, word signed or unsigned.
// - Byte mode multiplies two unsigned bytes.
// - Divide 32/16 and 16/16, signed and unsigned.
// - Quotient goes to register zero, remainder to register one.
// - Divisor any register; 32-bit dividend from aligned pair, odd high.
// - Divider iterates one cycle per divisor bit for both sizes.
// - DSP: 17x17 multiply, 40-bit shifter and adder, two accumulators.
// - Accumulator add, subtract and negate use only accumulators.
// - Control bits pick fractional/integer, sign mode and rounding.
// - Separate saturation enables for A, B, stores, plus mode bit.
// - DSP ops: zero, diff-square, multiply-accumulate or subtract, products; write-back.
module cae_engine (
  input  wire        sys_clk,
  input  wire        rst_n,
  input  wire        alu_go,
  input  wire [3:0]  alu_op,
  input  wire        alu_byte,
  input  wire [15:0] alu_a,
  input  wire [15:0] alu_b,
  input  wire        alu_carry_in,
  input  wire        alu_dst_mem,
  input  wire        mul_go,
  input  wire [2:0]  mul_mode,
  input  wire [15:0] mul_a,
  input  wire [15:0] mul_b,
  input  wire [4:0]  mul_lit,
  input  wire        div_go,
  input  wire        div_signed,
  input  wire        div_long,
  input  wire [15:0] div_lo_word,
  input  wire [15:0] div_hi_word,
  input  wire [15:0] divisor_register,
  input  wire        dsp_go,
  input  wire [3:0]  dsp_op,
  input  wire        dsp_sel_b,
  input  wire [15:0] dsp_x,
  input  wire [15:0] dsp_y,
  input  wire [5:0]  dsp_shift,
  input  wire        dsp_store_go,
  input  wire [15:0] core_control_word,
  output reg  [15:0] alu_result_q,
  output reg         alu_wr_reg_q,
  output reg         alu_wr_mem_q,
  output reg  [15:0] processor_status_word,
  output reg  [31:0] mul_result_q,
  output reg         mul_done_q,
  output reg  [15:0] quotient_register,
  output reg  [15:0] remainder_register,
  output reg         div_busy_q,
  output reg         div_done_q,
  output reg  [39:0] accumulator_a,
  output reg  [39:0] accumulator_b,
  output reg  [15:0] acc_store_q,
  output reg         acc_store_wr_q
);

  ////////////////////////////////////////////////////////////////////////////
  // Integer ALU, results and flags at byte or word width
  reg  [16:0] sum_w;
  reg  [4:0]  nib_w;
  reg  [15:0] res_w;
  reg         c_w, ov_w, dc_w, arith_w;
  wire [15:0] bsub = ~alu_b;
  wire        is_sub = (alu_op == `CAE_ALU_SUB);
  wire [15:0] bop  = is_sub ? bsub : alu_b;
  wire        cin  = is_sub ? 1'b1 : alu_carry_in;
  wire        msb_r = alu_byte ? res_w[7] : res_w[15];
  wire        zer_r = alu_byte ? (res_w[7:0] == 8'h00) : (res_w == 16'h0000);

  always @* begin
    sum_w   = 17'h00000;
    nib_w   = {1'b0, alu_a[3:0]} + {1'b0, bop[3:0]} + {4'h0, cin};
    res_w   = 16'h0000;
    c_w     = 1'b0;
    ov_w    = 1'b0;
    arith_w = 1'b0;
    dc_w    = nib_w[4];                                 // Borrow is inverted
    case (alu_op)
      `CAE_ALU_ADD, `CAE_ALU_SUB: begin
        arith_w = 1'b1;
        if (alu_byte) begin
          sum_w = {8'h00, {1'b0, alu_a[7:0]} + {1'b0, bop[7:0]} + {8'h00, cin}};
          res_w = {8'h00, sum_w[7:0]};
          c_w   = sum_w[8];
          ov_w  = (alu_a[7] == bop[7]) && (sum_w[7] != alu_a[7]);
        end else begin
          sum_w = {1'b0, alu_a} + {1'b0, bop} + {16'h0000, cin};
          res_w = sum_w[15:0];
          c_w   = sum_w[16];
          ov_w  = (alu_a[15] == bop[15]) && (sum_w[15] != alu_a[15]);
        end
      end
      `CAE_ALU_AND: res_w = alu_a & alu_b;
      `CAE_ALU_OR:  res_w = alu_a | alu_b;
      `CAE_ALU_XOR: res_w = alu_a ^ alu_b;
      `CAE_ALU_SHL: begin
        res_w = alu_a << 1;
        c_w   = alu_byte ? alu_a[7] : alu_a[15];
      end
      `CAE_ALU_LSR: begin
        res_w = alu_byte ? {9'h000, alu_a[7:1]} : {1'b0, alu_a[15:1]};
        c_w   = alu_a[0];
      end
      `CAE_ALU_ASR: begin
        res_w = alu_byte ? {8'h00, alu_a[7], alu_a[7:1]} : {alu_a[15], alu_a[15:1]};
        c_w   = alu_a[0];
      end
      default: res_w = 16'h0000;
    endcase
    if (alu_byte)
      res_w = {8'h00, res_w[7:0]};
  end

  // Flags update only for the class of operation that affects them
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      alu_result_q          <= 16'h0000;
      alu_wr_reg_q          <= 1'b0;
      alu_wr_mem_q          <= 1'b0;
      processor_status_word <= `CAE_SW_RESET;
    end else begin
      alu_wr_reg_q <= alu_go & ~alu_dst_mem;
      alu_wr_mem_q <= alu_go & alu_dst_mem;
      if (alu_go) begin
        alu_result_q <= res_w;
        processor_status_word[`CAE_SW_Z] <= zer_r;
        processor_status_word[`CAE_SW_N] <= msb_r;
        if (alu_op != `CAE_ALU_AND && alu_op != `CAE_ALU_OR && alu_op != `CAE_ALU_XOR)
          processor_status_word[`CAE_SW_C] <= c_w;
        if (arith_w) begin
          processor_status_word[`CAE_SW_SV] <= ov_w;
          processor_status_word[`CAE_SW_HC] <= dc_w;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Integer multiplier: both operands extended to 17 bits by mode
  reg  [16:0] ma, mb;
  always @* begin
    ma = {1'b0, mul_a};
    mb = {1'b0, mul_b};
    case (mul_mode)
      `CAE_MUL_SS: begin ma = {mul_a[15], mul_a}; mb = {mul_b[15], mul_b}; end
      `CAE_MUL_SU: ma = {mul_a[15], mul_a};
      `CAE_MUL_UXS: mb = {mul_b[15], mul_b};
      `CAE_MUL_SL: begin ma = {mul_a[15], mul_a}; mb = {12'h000, mul_lit}; end
      `CAE_MUL_UL: mb = {12'h000, mul_lit};
      `CAE_MUL_BB: begin ma = {9'h000, mul_a[7:0]}; mb = {9'h000, mul_b[7:0]}; end
      default: ma = {1'b0, mul_a};
    endcase
  end
  wire signed [33:0] mprod = $signed(ma) * $signed(mb);

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mul_result_q <= 32'h00000000;
      mul_done_q   <= 1'b0;
    end else begin
      mul_done_q <= mul_go;
      if (mul_go)
        mul_result_q <= mprod[31:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Restoring divider on magnitudes, one quotient bit per cycle.
  // A 32-bit dividend whose quotient overflows 16 bits gives wrong results.
  reg  [31:0] dvd_q;
  reg  [15:0] dvs_q;
  reg  [16:0] rem_q;
  reg  [4:0]  cnt_q;
  reg         qneg_q, rneg_q;
  wire        dneg   = div_signed & (div_long ? div_hi_word[15] : div_lo_word[15]);
  wire        sneg   = div_signed & divisor_register[15];
  wire [31:0] draw   = div_long ? {div_hi_word, div_lo_word}
                                : {{16{dneg}}, div_lo_word};
  wire [31:0] dmag   = dneg ? (~draw + 32'h00000001) : draw;
  wire [15:0] smag   = sneg ? (~divisor_register + 16'h0001) : divisor_register;
  wire [16:0] trial  = {rem_q[15:0], dvd_q[31]};
  wire        fits   = trial >= {1'b0, dvs_q};
  wire [15:0] qfin   = {dvd_q[14:0], fits};
  wire [16:0] rnext  = fits ? (trial - {1'b0, dvs_q}) : trial;

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dvd_q <= 32'h00000000; dvs_q <= 16'h0000; rem_q <= 17'h00000;
      cnt_q <= 5'h00; qneg_q <= 1'b0; rneg_q <= 1'b0;
      div_busy_q <= 1'b0; div_done_q <= 1'b0;
      quotient_register <= 16'h0000; remainder_register <= 16'h0000;
    end else begin
      div_done_q <= 1'b0;
      if (div_go && !div_busy_q) begin
        // Upper dividend bits preload the partial remainder
        rem_q      <= {1'b0, dmag[31:16]};
        dvd_q      <= {dmag[15:0], 16'h0000};
        dvs_q      <= smag;
        qneg_q     <= dneg ^ sneg;
        rneg_q     <= dneg;
        cnt_q      <= `CAE_DIV_CYC;
        div_busy_q <= 1'b1;
      end else if (div_busy_q) begin
        rem_q <= rnext;
        dvd_q <= {dvd_q[30:0], fits};
        cnt_q <= cnt_q - 5'h01;
        if (cnt_q == 5'h01) begin
          div_busy_q         <= 1'b0;
          div_done_q         <= 1'b1;
          quotient_register  <= qneg_q ? (~qfin + 16'h0001) : qfin;
          remainder_register <= rneg_q ? (~rnext[15:0] + 16'h0001) : rnext[15:0];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // DSP engine: operand sign per control word, fractional shift, shifter,
  // 40-bit adder, rounding and saturation
  wire [1:0]  dsp_sgn = {core_control_word[`CAE_CC_US1], core_control_word[`CAE_CC_US0]};
  wire [15:0] dxy    = dsp_x - dsp_y;
  wire        sq_op  = (dsp_op == `CAE_DSP_DSQ) || (dsp_op == `CAE_DSP_DSQA);
  wire        sqx_op = (dsp_op == `CAE_DSP_SQAC) || (dsp_op == `CAE_DSP_SQR);
  wire [15:0] opx    = sq_op ? dxy : dsp_x;
  wire [15:0] opy    = sq_op ? dxy : (sqx_op ? dsp_x : dsp_y);
  // Sign mode 0 signed, 1 unsigned, 2 mixed (x unsigned); difference squares stay signed
  wire        xs     = sq_op | (dsp_sgn == 2'h0);
  wire        ys     = sq_op | (dsp_sgn == 2'h0) | (dsp_sgn == 2'h2);
  wire signed [33:0] dprod = $signed({xs & opx[15], opx}) * $signed({ys & opy[15], opy});
  wire [39:0] pext   = {{6{dprod[33]}}, dprod};
  wire [39:0] pscl   = core_control_word[`CAE_CC_IF] ? pext : (pext << 1);
  wire [39:0] acc_t  = dsp_sel_b ? accumulator_b : accumulator_a;
  wire [39:0] acc_o  = dsp_sel_b ? accumulator_a : accumulator_b;
  // Barrel shift of the other accumulator: low 5 bits magnitude, bit 5 right
  // Own net keeps the right shift signed; a mixed conditional would make it logical
  wire signed [39:0] acc_asr = $signed(acc_o) >>> dsp_shift[4:0];
  wire [39:0] acc_sh = dsp_shift[5] ? $unsigned(acc_asr) : (acc_o << dsp_shift[4:0]);
  reg  [40:0] sum40;
  always @* begin
    case (dsp_op)
      `CAE_DSP_ZERO:  sum40 = 41'h0;
      `CAE_DSP_DSQ, `CAE_DSP_MULT, `CAE_DSP_SQR: sum40 = {pscl[39], pscl};
      `CAE_DSP_DSQA, `CAE_DSP_MULACC, `CAE_DSP_SQAC:
                      sum40 = {acc_t[39], acc_t} + {pscl[39], pscl};
      `CAE_DSP_MULNEG: sum40 = 41'h0 - {pscl[39], pscl};
      `CAE_DSP_MULSUB: sum40 = {acc_t[39], acc_t} - {pscl[39], pscl};
      `CAE_DSP_AADD:  sum40 = {acc_t[39], acc_t} + {acc_sh[39], acc_sh};
      `CAE_DSP_ASUB:  sum40 = {acc_t[39], acc_t} - {acc_sh[39], acc_sh};
      `CAE_DSP_NEG:   sum40 = 41'h0 - {acc_t[39], acc_t};
      default:        sum40 = {acc_t[39], acc_t};
    endcase
  end

  // Saturation, when enabled for the target accumulator: 40-bit overflow clamps; mode bit clear clamps at 32 bits
  wire        sat_en = dsp_sel_b ? core_control_word[`CAE_CC_BSAT]
                                 : core_control_word[`CAE_CC_ASAT];
  wire        m32    = ~core_control_word[`CAE_CC_ACSAT];
  wire        ovf40  = sum40[40] != sum40[39];
  wire        ovf32  = ~((sum40[39:31] == 9'h000) || (sum40[39:31] == 9'h1ff));
  wire [39:0] pos_v  = m32 ? 40'h007fffffff : 40'h7fffffffff;
  wire [39:0] neg_v  = m32 ? 40'hff80000000 : 40'h8000000000;
  wire [39:0] acc_n  = (sat_en && (ovf40 || (m32 && ovf32)))
                       ? (sum40[40] ? neg_v : pos_v) : sum40[39:0];

  // Store path: round to the high word, optional saturation of the store
  wire        rnd_cv = core_control_word[`CAE_CC_ROUND];
  wire        half   = acc_o[15:0] == 16'h8000;
  wire        up     = acc_o[15] & ~(rnd_cv & half & ~acc_o[16]);
  // Round-up lands on bit 16 of the accumulator, bit 1 of this slice
  wire [24:0] rhi    = acc_o[39:15] + {23'h000000, up, 1'b0};
  wire [23:0] rtop   = rhi[24:1];
  wire        s_ovf  = ~((rtop[23:15] == 9'h000) || (rtop[23:15] == 9'h1ff));
  wire [15:0] st_v   = (core_control_word[`CAE_CC_STSAT] && s_ovf)
                       ? (rtop[23] ? 16'h8000 : 16'h7fff) : rtop[15:0];
  wire        wb_op  = (dsp_op == `CAE_DSP_ZERO) || (dsp_op == `CAE_DSP_MULACC) ||
                       (dsp_op == `CAE_DSP_MULSUB) || (dsp_op == `CAE_DSP_PFS);

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      accumulator_a  <= 40'h0;
      accumulator_b  <= 40'h0;
      acc_store_q    <= 16'h0000;
      acc_store_wr_q <= 1'b0;
    end else begin
      acc_store_wr_q <= (dsp_go & dsp_store_go & wb_op);
      if (dsp_go && dsp_store_go && wb_op)
        acc_store_q <= st_v;
      if (dsp_go && dsp_op != `CAE_DSP_PFS) begin
        if (dsp_sel_b)
          accumulator_b <= acc_n;
        else
          accumulator_a <= acc_n;
      end
    end
  end

endmodule // cae_engine
`default_nettype wire

// file: hw/cae_engine_regs.vh
// Constants for the core arithmetic engine: opcodes, flag positions,
// control word fields, resets and timing. Included by the engine, the checker and the bench.
`ifndef CAE_ENGINE_REGS_VH
`define CAE_ENGINE_REGS_VH
// Integer ALU operations
`define CAE_ALU_ADD  4'h0
`define CAE_ALU_SUB  4'h1
`define CAE_ALU_AND  4'h2
`define CAE_ALU_OR   4'h3
`define CAE_ALU_XOR  4'h4
`define CAE_ALU_SHL  4'h5
`define CAE_ALU_LSR  4'h6
`define CAE_ALU_ASR  4'h7
// Integer multiply modes
`define CAE_MUL_SS   3'h0
`define CAE_MUL_UU   3'h1
`define CAE_MUL_SU   3'h2
`define CAE_MUL_UXS  3'h3
`define CAE_MUL_SL   3'h4
`define CAE_MUL_UL   3'h5
`define CAE_MUL_BB   3'h6
// DSP operations
`define CAE_DSP_ZERO 4'h0
`define CAE_DSP_DSQ    4'h1
`define CAE_DSP_DSQA   4'h2
`define CAE_DSP_MULACC 4'h3
`define CAE_DSP_SQAC   4'h4
`define CAE_DSP_MULT   4'h5
`define CAE_DSP_SQR    4'h6
`define CAE_DSP_MULNEG 4'h7
`define CAE_DSP_MULSUB 4'h8
`define CAE_DSP_PFS  4'h9
`define CAE_DSP_AADD 4'ha
`define CAE_DSP_ASUB 4'hb
`define CAE_DSP_NEG  4'hc
// Status word bit positions
`define CAE_SW_C     0
`define CAE_SW_Z     1
`define CAE_SW_SV    2
`define CAE_SW_N     3
`define CAE_SW_HC    8
// Core control word bit positions
`define CAE_CC_IF    0
`define CAE_CC_ROUND 1
`define CAE_CC_US0   2
`define CAE_CC_US1   3
`define CAE_CC_STSAT 4
`define CAE_CC_ACSAT 5
`define CAE_CC_BSAT  6
`define CAE_CC_ASAT  7
// Reset values and timing
`define CAE_SW_RESET 16'h0000
`define CAE_DIV_CYC  5'h10
`endif

// file: test/cae_wreg_model.sv
// Working register file model: eight words that feed the divider.
// Assumes the bench loads words before a divide and holds the selects.
`timescale 1ns/1ps
`default_nettype none
module cae_wreg_model (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        wr_en,
  input  wire logic [2:0]  wr_idx,
  input  wire logic [15:0] wr_val,
  input  wire logic [1:0]  pair_sel,
  input  wire logic [2:0]  dsr_idx,
  input  wire logic        div_done_q,
  input  wire logic [15:0] quotient_register,
  input  wire logic [15:0] remainder_register,
  output logic      [15:0] div_lo_word,
  output logic      [15:0] div_hi_word,
  output logic      [15:0] divisor_register
);
  logic [15:0] rf_q [0:7];
  // Even word is the low half, odd word the high half
  assign div_lo_word = rf_q[{pair_sel, 1'b0}];
  assign div_hi_word = rf_q[{pair_sel, 1'b1}];
  assign divisor_register = rf_q[dsr_idx];
  // Results win over a load in the same cycle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 8; i++) rf_q[i] <= 16'h0000;
    end else if (div_done_q) begin
      rf_q[0] <= quotient_register;
      rf_q[1] <= remainder_register;
    end else if (wr_en) begin
      rf_q[wr_idx] <= wr_val;
    end
  end
endmodule // cae_wreg_model
`default_nettype wire

// file: test/cae_engine_asserts.sv
// Checker for the arithmetic engine, bound to its ports.
// Assumes one clock domain and the constants header on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "cae_engine_regs.vh"
module cae_engine_asserts (
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic        alu_go,
  input wire logic [3:0]  alu_op,
  input wire logic        alu_byte,
  input wire logic        alu_dst_mem,
  input wire logic        mul_go,
  input wire logic [2:0]  mul_mode,
  input wire logic [15:0] mul_a,
  input wire logic [15:0] mul_b,
  input wire logic        div_go,
  input wire logic        dsp_go,
  input wire logic [3:0]  dsp_op,
  input wire logic        dsp_store_go,
  input wire logic [15:0] alu_result_q,
  input wire logic        alu_wr_reg_q,
  input wire logic        alu_wr_mem_q,
  input wire logic [15:0] processor_status_word,
  input wire logic [31:0] mul_result_q,
  input wire logic        mul_done_q,
  input wire logic        div_busy_q,
  input wire logic        div_done_q,
  input wire logic [39:0] accumulator_a,
  input wire logic [39:0] accumulator_b,
  input wire logic        acc_store_wr_q
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////
  a_div_span: assert property (
    $rose(div_busy_q) |-> div_busy_q[*8] ##9 (div_done_q && !div_busy_q))
    else $error("divide length wrong");
  a_div_take: assert property (
    div_go && !div_busy_q |=> div_busy_q) else $error("divide not started");
  a_alu_target: assert property (
    alu_go |=> alu_wr_mem_q == $past(alu_dst_mem) && alu_wr_reg_q == !$past(alu_dst_mem))
    else $error("write target wrong");
  a_alu_byte: assert property (
    alu_go && alu_byte |=> alu_result_q[15:8] == 8'h00) else $error("byte result high");
  a_alu_zero: assert property (
    alu_go && alu_op < 4'h5 |=> processor_status_word[`CAE_SW_Z] == (alu_result_q == 16'h0000))
    else $error("zero flag wrong");
  a_mul_unsigned: assert property (
    mul_go && mul_mode == `CAE_MUL_UU |=> mul_done_q && mul_result_q == $past(mul_a) * $past(mul_b))
    else $error("unsigned product wrong");
  a_pfs_hold: assert property (
    dsp_go && dsp_op == `CAE_DSP_PFS |=> $stable(accumulator_a) && $stable(accumulator_b))
    else $error("prefetch store moved an accumulator");
  a_store_cause: assert property (
    acc_store_wr_q |-> $past(dsp_go) && $past(dsp_store_go)) else $error("stray store");
endmodule // cae_engine_asserts
bind cae_engine cae_engine_asserts cae_engine_asserts_i (.*);
`default_nettype wire

// file: test/testbench.sv
// Self-checking bench for the arithmetic engine and register file model.
// Assumes engine, header, model and checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
`include "cae_engine_regs.vh"
module testbench;
  logic sys_clk = 0, rst_n = 0, alu_go = 0, alu_byte = 0, alu_carry_in = 0, alu_dst_mem = 0;
  logic mul_go = 0, div_go = 0, div_signed = 0, div_long = 0, wr_en = 0;
  logic dsp_go = 0, dsp_sel_b = 0, dsp_store_go = 0;
  logic [3:0] alu_op = 0, dsp_op = 0;
  logic [2:0] mul_mode = 0, wr_idx = 0, dsr_idx = 0;
  logic [1:0] pair_sel = 0;
  logic [4:0] mul_lit = 0;
  logic [5:0] dsp_shift = 0;
  logic [15:0] alu_a = 0, alu_b = 0, mul_a = 0, mul_b = 0, dsp_x = 0, dsp_y = 0;
  logic [15:0] core_control_word = 0, wr_val = 0;
  wire [15:0] alu_result_q, processor_status_word, quotient_register, remainder_register;
  wire [15:0] div_lo_word, div_hi_word, divisor_register, acc_store_q;
  wire [31:0] mul_result_q;
  wire [39:0] accumulator_a, accumulator_b;
  wire alu_wr_reg_q, alu_wr_mem_q, mul_done_q, div_busy_q, div_done_q, acc_store_wr_q;
  int n_errors = 0, compares = 0, cyc = 0;
  logic [31:0] seed = 32'h0000d992;
  cae_engine cae_engine_i (.*);
  cae_wreg_model cae_wreg_model_i (.*);
  always #20 sys_clk = ~sys_clk;
  // Run takes about 840 cycles; the ceiling leaves wide margin
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 8000) begin
      n_errors++;
      end_of_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  function automatic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Returns {carry, overflow, negative, zero, result}
  function automatic [19:0] alu_f(input [3:0] op, input bt, ci, input [15:0] a, b);
    logic [16:0] s;
    logic [15:0] m, bb, r;
    int w;
    m = bt ? 16'h00ff : 16'hffff;
    w = bt ? 7 : 15;
    bb = ((op == `CAE_ALU_SUB) ? ~b : b) & m;
    case (op)
      `CAE_ALU_ADD, `CAE_ALU_SUB: s = (a & m) + bb + ((op == `CAE_ALU_SUB) ? 1'b1 : ci);
      `CAE_ALU_AND: s = a & b;
      `CAE_ALU_OR: s = a | b;
      `CAE_ALU_XOR: s = a ^ b;
      `CAE_ALU_SHL: s = a << 1;
      `CAE_ALU_LSR: s = (a & m) >> 1;
      default: s = ((a & m) >> 1) | (a[w] << w);
    endcase
    r = s[15:0] & m;
    return {bt ? s[8] : s[16], a[w] == bb[w] && r[w] != a[w], r[w], r == 16'h0000, r};
  endfunction
  function automatic [31:0] mul_f(input [2:0] md, input [15:0] a, b, input [4:0] lt);
    logic signed [16:0] x, y;
    logic signed [33:0] pr;
    x = {(md == `CAE_MUL_SS || md == `CAE_MUL_SU || md == `CAE_MUL_SL) & a[15], a};
    y = {(md == `CAE_MUL_SS || md == `CAE_MUL_UXS) & b[15], b};
    if (md == `CAE_MUL_SL || md == `CAE_MUL_UL) y = {12'h000, lt};
    if (md == `CAE_MUL_BB) x = {9'h000, a[7:0]};
    if (md == `CAE_MUL_BB) y = {9'h000, b[7:0]};
    pr = x * y;
    return pr[31:0];
  endfunction
  // Returns {remainder, quotient}
  function automatic [31:0] div_f(input s, l, input [15:0] lo, hi, d);
    logic signed [31:0] n, dv;
    n = l ? {hi, lo} : {s ? {16{lo[15]}} : 16'h0000, lo};
    dv = {s ? {16{d[15]}} : 16'h0000, d};
    if (s) return {16'(n % dv), 16'(n / dv)};
    return {16'($unsigned(n) % $unsigned(dv)), 16'($unsigned(n) / $unsigned(dv))};
  endfunction
  function automatic [39:0] dsp_f(input [3:0] op, input [39:0] t, o, input [15:0] x, y, input fr);
    logic signed [39:0] xs, ys, pr, sq, ed;
    xs = {{24{x[15]}}, x};
    ys = {{24{y[15]}}, y};
    pr = (xs * ys) <<< fr;
    sq = (xs * xs) <<< fr;
    ed = ((xs - ys) * (xs - ys)) <<< fr;
    case (op)
      `CAE_DSP_ZERO: return 40'h0000000000;
      `CAE_DSP_DSQ: return ed;
      `CAE_DSP_DSQA: return t + ed;
      `CAE_DSP_MULACC: return t + pr;
      `CAE_DSP_SQAC: return t + sq;
      `CAE_DSP_MULT: return pr;
      `CAE_DSP_SQR: return sq;
      `CAE_DSP_MULNEG: return -pr;
      `CAE_DSP_MULSUB: return t - pr;
      `CAE_DSP_AADD: return t + o;
      `CAE_DSP_ASUB: return t - o;
      `CAE_DSP_NEG: return -t;
      default: return t;
    endcase
  endfunction
  task automatic wreg(input int ix, input logic [15:0] v);
    @(posedge sys_clk);
    {wr_en, wr_idx, wr_val} <= {1'b1, 3'(ix), v};
    @(posedge sys_clk);
    wr_en <= 1'b0;
  endtask
  task automatic dsp(input [3:0] op, input sb, st, input [15:0] x, y);
    @(posedge sys_clk);
    {dsp_go, dsp_op, dsp_sel_b, dsp_store_go, dsp_x, dsp_y} <= {1'b1, op, sb, st, x, y};
    @(posedge sys_clk);
    dsp_go <= 1'b0;
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    logic [3:0] op;
    logic [2:0] md;
    logic bt, ci;
    logic [15:0] a, b, d, hi;
    logic [19:0] e;
    logic [31:0] q;
    logic [39:0] ea, eb;
    int n, p;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    // Integer ALU: two overflow and borrow corners, then random
    for (int i = 0; i < 48; i++) begin
      op = (i < 2) ? i : rnd() % 8;
      bt = (i < 2) ? i : rnd() % 2;
      ci = (i < 2) ? 1'b0 : rnd() % 2;
      a = (i == 0) ? 16'h7fff : (i == 1) ? 16'h0000 : rnd();
      b = (op > 4 || i < 2) ? 16'h0001 : rnd();
      e = alu_f(op, bt, ci, a, b);
      @(posedge sys_clk);
      {alu_go, alu_op, alu_byte, alu_carry_in, alu_a, alu_b} <= {1'b1, op, bt, ci, a, b};
      alu_dst_mem <= bt ^ ci;
      @(posedge sys_clk);
      alu_go <= 1'b0;
      #1;
      chk(alu_result_q, e[15:0]);
      chk(processor_status_word[`CAE_SW_Z], e[16]);
      chk(processor_status_word[`CAE_SW_N], e[17]);
      if (op < 2) chk({processor_status_word[`CAE_SW_SV], processor_status_word[`CAE_SW_C]}, {e[18], e[19]});
      chk(alu_wr_mem_q, bt ^ ci);
    end
    $display("test alu finished");
    // Every multiply mode four times
    for (int i = 0; i < 28; i++) begin
      md = i % 7;
      a = rnd();
      b = rnd();
      @(posedge sys_clk);
      {mul_go, mul_mode, mul_a, mul_b, mul_lit} <= {1'b1, md, a, b, 5'(i * 3)};
      @(posedge sys_clk);
      mul_go <= 1'b0;
      #1;
      chk({mul_done_q, mul_result_q}, {1'b1, mul_f(md, a, b, 5'(i * 3))});
    end
    $display("test multiply finished");
    // Divides of all four kinds; go is held into the busy cycle to be refused
    for (int i = 0; i < 24; i++) begin
      bt = i % 2;
      ci = (i / 2) % 2;
      d = (rnd() & 16'hfffe) | 16'h0002;
      a = rnd();
      hi = !ci ? rnd() : bt ? {16{a[15]}} : rnd() % d;
      p = 1 + rnd() % 3;
      wreg(2 * p, a);
      wreg(2 * p + 1, hi);
      wreg((2 * p + 2) % 8, d);
      @(posedge sys_clk);
      {div_go, div_signed, div_long, pair_sel, dsr_idx} <= {1'b1, bt, ci, 2'(p), 3'((2 * p + 2) % 8)};
      @(posedge sys_clk);
      @(posedge sys_clk);
      div_go <= 1'b0;
      n = 1;
      #1;
      while (!div_done_q && n < 40) begin
        @(posedge sys_clk);
        #1;
        n++;
      end
      q = div_f(bt, ci, a, hi, d);
      chk(n, 16);
      chk({remainder_register, quotient_register}, q);
      @(posedge sys_clk);
      #1;
      chk({cae_wreg_model_i.rf_q[1], cae_wreg_model_i.rf_q[0]}, q);
    end
    $display("test divide finished");
    // Every DSP operation, integer then fractional
    ea = 40'h0000000000;
    eb = 40'h0000000000;
    for (int i = 0; i < 26; i++) begin
      core_control_word <= {15'h0000, i < 13};
      op = i % 13;
      bt = rnd() % 2;
      a = rnd();
      a[15] = a[14];
      b = rnd();
      b[15] = b[14];
      if (bt) eb = dsp_f(op, eb, ea, a, b, i >= 13);
      else ea = dsp_f(op, ea, eb, a, b, i >= 13);
      dsp(op, bt, 1'b0, a, b);
      chk(accumulator_a, ea);
      chk(accumulator_b, eb);
    end
    // Saturation: clamp in 32-bit mode, no clamp in 40-bit mode
    for (int k = 0; k < 2; k++) begin
      core_control_word <= k ? 16'h00a1 : 16'h0081;
      dsp(`CAE_DSP_ZERO, 1'b0, 1'b0, a, b);
      repeat (3) dsp(`CAE_DSP_MULACC, 1'b0, 1'b0, 16'h7fff, 16'h7fff);
      chk(accumulator_a, k ? 40'h00bffd0003 : 40'h007fffffff);
    end
    // Store of the other accumulator, rounded
    core_control_word <= 16'h0001;
    dsp(`CAE_DSP_MULT, 1'b1, 1'b0, 16'h1234, 16'h1000);
    dsp(`CAE_DSP_PFS, 1'b0, 1'b1, 16'h0000, 16'h0000);
    chk({acc_store_wr_q, acc_store_q}, {1'b1, 16'h0123});
    dsp(`CAE_DSP_MULT, 1'b1, 1'b0, 16'h0003, 16'h5000);
    dsp(`CAE_DSP_PFS, 1'b0, 1'b1, 16'h0000, 16'h0000);
    chk({acc_store_wr_q, acc_store_q}, {1'b1, 16'h0001});
    // Convergent rounding: an exact half with even upper word stays down
    core_control_word <= 16'h0003;
    dsp(`CAE_DSP_MULT, 1'b1, 1'b0, 16'h0002, 16'h4000);
    dsp(`CAE_DSP_PFS, 1'b0, 1'b1, 16'h0000, 16'h0000);
    chk({acc_store_wr_q, acc_store_q}, {1'b1, 16'h0000});
    // Arithmetic right shift of a negative other accumulator
    dsp_shift <= 6'h21;
    dsp(`CAE_DSP_NEG, 1'b0, 1'b0, 16'h0000, 16'h0000);
    dsp(`CAE_DSP_AADD, 1'b1, 1'b0, 16'h0000, 16'h0000);
    chk(accumulator_b, 40'hffa001fffe);
    $display("test dsp finished");
    end_of_test();
  end
endmodule // testbench
`default_nettype wire
